// *** pkg/astg_pkg.sv ***
package astg_pkg;

    // register byte offsets
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_TSEL   = 8'h04;
    localparam logic [7:0] ADR_TCFG   = 8'h08;
    localparam logic [7:0] ADR_TSW    = 8'h0C;
    localparam logic [7:0] ADR_FPB    = 8'h10;
    localparam logic [7:0] ADR_STATUS = 8'h14;

    // ctrl fields
    localparam int CTRL_STD_BIT   = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_STOP_BIT  = 2;
    localparam int CTRL_CONT_BIT  = 3;
    localparam int CTRL_ARMED_BIT = 4;

    // trigger config fields
    localparam int TCFG_GATE_BIT = 0;
    localparam int TCFG_ORG_LSB  = 1;
    localparam int TCFG_POL_BIT  = 3;

    // status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_ARMED_BIT = 2;
    localparam int STAT_CNT_LSB   = 8;

    // trigger target select
    localparam logic TGT_ACQ   = 1'b0;
    localparam logic TGT_FRAME = 1'b1;

    // trigger origin select
    localparam logic [1:0] ORG_SOFT  = 2'h0;
    localparam logic [1:0] ORG_LINE1 = 2'h1;
    localparam logic [1:0] ORG_LINE2 = 2'h2;

    // edge polarity select
    localparam logic POL_RISE = 1'b0;
    localparam logic POL_FALL = 1'b1;

    // reset values, and the smallest accepted fpb
    localparam logic       RST_STD  = 1'b0;
    localparam logic       RST_CONT = 1'b1;
    localparam logic       RST_GATE = 1'b0;
    localparam logic [1:0] RST_ORG  = ORG_LINE2;
    localparam logic       RST_POL  = POL_RISE;
    localparam logic [7:0] RST_FPB  = 8'h01;
    localparam logic [7:0] FPB_MIN  = 8'h01;

    localparam int NUM_LINES = 2;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_WAIT_ACQ = 2'b01,
        ST_WAIT_FRM = 2'b10
    } astg_state_t;

endpackage

// *** pkg/astg_cnt_if.sv ***
`timescale 1ns/1ps
interface astg_cnt_if;
    logic       clear;
    logic       inc;
    logic [7:0] fpb;
    logic [7:0] count;
    logic       last;

    modport ctl (output clear, output inc, output fpb,
                 input count, input last);
    modport cnt (input clear, input inc, input fpb,
                 output count, output last);
endinterface

// *** design/astg_line_edge.sv ***
`timescale 1ns/1ps
module astg_line_edge (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // raw line
    input  wire logic i_line,
    // one-cycle edge pulses
    output logic      o_rise,
    output logic      o_fall
);
    logic meta_q;
    logic sync_q;
    logic hist_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            hist_q <= 1'b0;
        end else begin
            meta_q <= i_line;
            sync_q <= meta_q;
            hist_q <= sync_q;
        end
    end

    assign o_rise = sync_q & ~hist_q;
    assign o_fall = ~sync_q & hist_q;
endmodule

// *** design/astg_burst_cnt.sv ***
`timescale 1ns/1ps
module astg_burst_cnt (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // counter control
    astg_cnt_if.cnt   c
);
    logic [7:0] count_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_q <= 8'h00;
        end else if (c.clear) begin
            count_q <= 8'h00;
        end else if (c.inc && count_q != 8'hFF) begin
            count_q <= count_q + 8'h01;
        end
    end

    assign c.count = count_q;
    assign c.last  = c.inc && (count_q + 8'h01 == c.fpb);
endmodule

// *** design/astg_top.sv ***
`timescale 1ns/1ps
module astg_top (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // external input lines
    input  wire logic        i_line1,
    input  wire logic        i_line2,
    // frame start side
    input  wire logic        i_frame_trig,
    output logic             o_expose_start,
    output logic             o_wait_acq_start,
    output logic             o_wait_frame_start,
    // frame start trigger settings
    output logic             o_fs_gate_enable,
    output logic       [1:0] o_fs_origin,
    output logic             o_fs_polarity,
    output logic             o_fs_sw_trig
);
    astg_pkg::astg_state_t state_q;
    astg_pkg::astg_state_t state_d;

    logic       ack_q;
    logic [31:0] rdat_q;
    logic       std_mode_q;
    logic       cont_mode_q;
    logic       armed_q;
    logic       target_q;
    logic       as_gate_q;
    logic [1:0] as_origin_q;
    logic       as_pol_q;
    logic       fs_gate_q;
    logic [1:0] fs_origin_q;
    logic       fs_pol_q;
    logic [7:0] fpb_q;
    logic       as_sw_q;
    logic       fs_sw_q;
    logic       gate_prev_q;
    logic       expose_q;

    logic       req;
    logic       wr;
    logic       wr0;
    logic       start_cmd;
    logic       stop_cmd;
    logic       ctrl_wr;
    logic       tsel_wr;
    logic       tcfg_wr;
    logic       tsw_wr;
    logic       fpb_wr;
    logic       acq_event;
    logic       frame_ok;

    localparam int NL = astg_pkg::NUM_LINES;

    logic [NL-1:0] rise;
    logic [NL-1:0] fall;

    astg_cnt_if cnt_if ();

    function automatic logic pick_edge(input logic r, input logic f,
                                       input logic pol);
        pick_edge = (pol == astg_pkg::POL_FALL) ? f : r;
    endfunction

    function automatic logic reg_hit(input logic       w,
                                     input logic [7:0] a,
                                     input logic [7:0] slot);
        reg_hit = w && a == slot;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NL; g++) begin : g_line
            astg_line_edge u_edge (
                .i_clk  (i_clk),
                .i_rst  (i_rst),
                .i_line ((g == 0) ? i_line1 : i_line2),
                .o_rise (rise[g]),
                .o_fall (fall[g])
            );
        end
    endgenerate

    astg_burst_cnt u_cnt (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .c     (cnt_if.cnt)
    );

    // bus: one wait state, writes land on the acked edge
    assign req = i_wb_cyc & i_wb_stb;
    assign wr  = req & i_wb_we & ack_q;
    assign wr0 = wr & i_wb_sel[0];
    assign ctrl_wr = reg_hit(wr0, i_wb_adr, astg_pkg::ADR_CTRL);
    assign tsel_wr = reg_hit(wr0, i_wb_adr, astg_pkg::ADR_TSEL);
    assign tcfg_wr = reg_hit(wr0, i_wb_adr, astg_pkg::ADR_TCFG);
    assign tsw_wr  = reg_hit(wr0, i_wb_adr, astg_pkg::ADR_TSW);
    assign fpb_wr  = reg_hit(wr0, i_wb_adr, astg_pkg::ADR_FPB);
    assign start_cmd = ctrl_wr && i_wb_dat[astg_pkg::CTRL_START_BIT];
    assign stop_cmd  = ctrl_wr && i_wb_dat[astg_pkg::CTRL_STOP_BIT];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdat_q <= 32'h0000_0000;
        end else if (req & ~ack_q) begin
            rdat_q <= 32'h0000_0000;
            unique case (i_wb_adr)
                astg_pkg::ADR_CTRL: begin
                    rdat_q[astg_pkg::CTRL_STD_BIT]   <= std_mode_q;
                    rdat_q[astg_pkg::CTRL_CONT_BIT]  <= cont_mode_q;
                    rdat_q[astg_pkg::CTRL_ARMED_BIT] <= armed_q;
                end
                astg_pkg::ADR_TSEL: begin
                    rdat_q[0] <= target_q;
                end
                astg_pkg::ADR_TCFG: begin
                    rdat_q[astg_pkg::TCFG_GATE_BIT] <=
                        (target_q == astg_pkg::TGT_ACQ) ? as_gate_q
                                                        : fs_gate_q;
                    rdat_q[astg_pkg::TCFG_ORG_LSB +: 2] <=
                        (target_q == astg_pkg::TGT_ACQ) ? as_origin_q
                                                        : fs_origin_q;
                    rdat_q[astg_pkg::TCFG_POL_BIT] <=
                        (target_q == astg_pkg::TGT_ACQ) ? as_pol_q
                                                        : fs_pol_q;
                end
                astg_pkg::ADR_FPB: begin
                    rdat_q[7:0] <= fpb_q;
                end
                astg_pkg::ADR_STATUS: begin
                    rdat_q[astg_pkg::STAT_STATE_LSB +: 2] <= state_q;
                    rdat_q[astg_pkg::STAT_ARMED_BIT]      <= armed_q;
                    rdat_q[astg_pkg::STAT_CNT_LSB +: 8]   <= cnt_if.count;
                end
                default: begin
                    rdat_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    // mode and command bits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            std_mode_q  <= astg_pkg::RST_STD;
            cont_mode_q <= astg_pkg::RST_CONT;
        end else if (ctrl_wr) begin
            std_mode_q  <= i_wb_dat[astg_pkg::CTRL_STD_BIT];
            cont_mode_q <= i_wb_dat[astg_pkg::CTRL_CONT_BIT];
        end
    end

    // single frame mode disarms after one exposure
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            armed_q <= 1'b0;
        end else if (stop_cmd) begin
            armed_q <= 1'b0;
        end else if (start_cmd) begin
            armed_q <= 1'b1;
        end else if (frame_ok && !cont_mode_q) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            target_q <= astg_pkg::TGT_ACQ;
        end else if (tsel_wr) begin
            target_q <= i_wb_dat[0];
        end
    end

    // per-target trigger settings
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            as_gate_q   <= astg_pkg::RST_GATE;
            as_origin_q <= astg_pkg::RST_ORG;
            as_pol_q    <= astg_pkg::RST_POL;
            fs_gate_q   <= astg_pkg::RST_GATE;
            fs_origin_q <= astg_pkg::RST_ORG;
            fs_pol_q    <= astg_pkg::RST_POL;
        end else if (tcfg_wr) begin
            if (target_q == astg_pkg::TGT_ACQ) begin
                as_gate_q   <= i_wb_dat[astg_pkg::TCFG_GATE_BIT];
                as_origin_q <= i_wb_dat[astg_pkg::TCFG_ORG_LSB +: 2];
                as_pol_q    <= i_wb_dat[astg_pkg::TCFG_POL_BIT];
            end else begin
                fs_gate_q   <= i_wb_dat[astg_pkg::TCFG_GATE_BIT];
                fs_origin_q <= i_wb_dat[astg_pkg::TCFG_ORG_LSB +: 2];
                fs_pol_q    <= i_wb_dat[astg_pkg::TCFG_POL_BIT];
            end
        end
    end

    // zero would end a burst only after 256 frames, so it is refused
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fpb_q <= astg_pkg::RST_FPB;
        end else if (fpb_wr && i_wb_dat[7:0] >= astg_pkg::FPB_MIN) begin
            fpb_q <= i_wb_dat[7:0];
        end
    end

    // soft trigger pulses, one cycle after the write
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            as_sw_q <= 1'b0;
            fs_sw_q <= 1'b0;
        end else begin
            as_sw_q <= tsw_wr && i_wb_dat[0]
                       && target_q == astg_pkg::TGT_ACQ;
            fs_sw_q <= tsw_wr && i_wb_dat[0]
                       && target_q == astg_pkg::TGT_FRAME;
        end
    end

    // acquisition start event source
    always_comb begin
        unique case (as_origin_q)
            astg_pkg::ORG_SOFT:  acq_event = as_sw_q;
            astg_pkg::ORG_LINE1: acq_event =
                pick_edge(rise[0], fall[0], as_pol_q);
            astg_pkg::ORG_LINE2: acq_event =
                pick_edge(rise[1], fall[1], as_pol_q);
            default:             acq_event = 1'b0;
        endcase
    end

    assign frame_ok = state_q == astg_pkg::ST_WAIT_FRM && i_frame_trig;

    assign cnt_if.fpb   = fpb_q;
    assign cnt_if.inc   = frame_ok;
    assign cnt_if.clear = state_q != astg_pkg::ST_WAIT_FRM
                          && state_d == astg_pkg::ST_WAIT_FRM;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            astg_pkg::ST_IDLE: begin
                if (std_mode_q && armed_q) begin
                    if (as_gate_q) begin
                        state_d = astg_pkg::ST_WAIT_ACQ;
                    end else begin
                        state_d = astg_pkg::ST_WAIT_FRM;
                    end
                end
            end
            astg_pkg::ST_WAIT_ACQ: begin
                if (!as_gate_q) begin
                    state_d = astg_pkg::ST_WAIT_FRM;
                end else if (acq_event) begin
                    state_d = astg_pkg::ST_WAIT_FRM;
                end
            end
            astg_pkg::ST_WAIT_FRM: begin
                if (as_gate_q && !gate_prev_q) begin
                    state_d = astg_pkg::ST_WAIT_ACQ;
                end else if (cnt_if.last && as_gate_q) begin
                    state_d = astg_pkg::ST_WAIT_ACQ;
                end
            end
            default: begin
                state_d = astg_pkg::ST_IDLE;
            end
        endcase
        // events elsewhere fall through unused
        if (!std_mode_q || !armed_q || stop_cmd) begin
            state_d = astg_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q     <= astg_pkg::ST_IDLE;
            gate_prev_q <= astg_pkg::RST_GATE;
        end else begin
            state_q     <= state_d;
            gate_prev_q <= as_gate_q;
        end
    end

    // legacy mode passes frame triggers ungated
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            expose_q <= 1'b0;
        end else begin
            expose_q <= frame_ok || (!std_mode_q && i_frame_trig);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wait_acq_start   <= 1'b0;
            o_wait_frame_start <= 1'b0;
        end else begin
            o_wait_acq_start   <= state_d == astg_pkg::ST_WAIT_ACQ;
            o_wait_frame_start <= state_d == astg_pkg::ST_WAIT_FRM;
        end
    end

    assign o_wb_ack         = ack_q;
    assign o_wb_dat         = rdat_q;
    assign o_expose_start   = expose_q;
    assign o_fs_gate_enable = fs_gate_q;
    assign o_fs_origin      = fs_origin_q;
    assign o_fs_polarity    = fs_pol_q;
    assign o_fs_sw_trig     = fs_sw_q;
endmodule

// *** sim/astg_trig_src.sv ***
`timescale 1ns/1ps
module astg_trig_src (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // requests from the bench
    input  wire logic i_flip,
    input  wire logic i_noise,
    // trigger lines
    output logic      o_line1,
    output logic      o_line2
);
    // one clean edge per request, level held between, no bounce
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_line1 <= 1'b0;
        end else if (i_flip) begin
            o_line1 <= ~o_line1;
        end
    end

    // unselected line chatters every cycle so a leak shows up
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_line2 <= 1'b0;
        end else begin
            o_line2 <= i_noise ? ~o_line2 : 1'b0;
        end
    end
endmodule

// *** sim/astg_top_sva.sv ***
`timescale 1ns/1ps
module astg_top_sva (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_wb_cyc,
    input wire logic       i_wb_stb,
    input wire logic       i_frame_trig,
    input wire logic       o_wb_ack,
    input wire logic       o_expose_start,
    input wire logic       o_wait_acq_start,
    input wire logic       o_wait_frame_start,
    input wire logic [1:0] o_fs_origin,
    input wire logic       o_fs_sw_trig
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_expose_cause;
        o_expose_start |-> $past(i_frame_trig);
    endproperty
    a_expose_cause: assert property (p_expose_cause)
        else $error("exposure without frame trigger");
    property p_drop;
        i_frame_trig && o_wait_acq_start |=> !o_expose_start;
    endproperty
    a_drop: assert property (p_drop)
        else $error("frame trigger not dropped");
    property p_take;
        i_frame_trig && o_wait_frame_start |=> o_expose_start;
    endproperty
    a_take: assert property (p_take)
        else $error("frame trigger not taken");
    property p_excl;
        !(o_wait_acq_start && o_wait_frame_start);
    endproperty
    a_excl: assert property (p_excl)
        else $error("two waiting states at once");
    property p_sw_pulse;
        o_fs_sw_trig |=> !o_fs_sw_trig;
    endproperty
    a_sw_pulse: assert property (p_sw_pulse)
        else $error("soft trigger longer than a cycle");
    property p_origin_rst;
        $fell(i_rst) |-> o_fs_origin == astg_pkg::ORG_LINE2;
    endproperty
    a_origin_rst: assert property (p_origin_rst)
        else $error("origin not line two after reset");
    property p_ack_ans;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
    endproperty
    a_ack_ans: assert property (p_ack_ans)
        else $error("bus answer late");
    property p_ack_pulse;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than a cycle");
endmodule

// *** sim/astg_top_bench.sv ***
`timescale 1ns/1ps
module astg_top_bench;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, fr = 0;
    logic        flip = 0, noise = 0;
    logic [7:0]  adr = 8'h00, fpb;
    logic [31:0] wdat = 32'h0, seed = 32'h0DBA;
    logic [63:0] q[$];
    wire  [31:0] rdat;
    wire  [1:0]  forg;
    wire         ack, exps, wacq, wfrm, fgate, fpol, fsw, l1, l2;
    int          bad_count = 0, num_checks = 0, n_exp = 0, n_sw = 0;
    int          want = 0, cyc_n = 0;

    always #4 clk = ~clk;

    astg_top DUT (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_line1(l1), .i_line2(l2),
        .i_frame_trig(fr), .o_expose_start(exps), .o_wait_acq_start(wacq),
        .o_wait_frame_start(wfrm), .o_fs_gate_enable(fgate),
        .o_fs_origin(forg), .o_fs_polarity(fpol), .o_fs_sw_trig(fsw));
    astg_trig_src SRC (.i_clk(clk), .i_rst(rst), .i_flip(flip),
        .i_noise(noise), .o_line1(l1), .o_line2(l2));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp);
    endtask
    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hold the whole request until ack is seen, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        q.push_back({m, e});
        wb(1'b0, a, 32'h0);
    endtask
    task automatic trig(input int e);
        want += e;
        @(posedge clk) fr <= 1'b1;
        @(posedge clk) fr <= 1'b0;
        repeat (2 + rnd() % 3) @(posedge clk);
    endtask
    task automatic edge_line;
        @(posedge clk) flip <= 1'b1;
        @(posedge clk) flip <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic burst(input int n);
        repeat (n) trig(1);
        chk_out(n_exp, want);
        rd(astg_pkg::ADR_STATUS, 32'h5, 32'h7);
        chk_out({30'h0, wacq, wfrm}, 32'h2);
    endtask

    always @(posedge clk) begin
        logic [63:0] t;
        if (ack === 1'b1 && cyc && !we && q.size() > 0) begin
            t = q.pop_front();
            chk_rd(rdat & t[63:32], t[31:0]);
        end
        if (exps === 1'b1) n_exp++;
        if (fsw === 1'b1) n_sw++;
        cyc_n++;
        // whole run needs a few hundred cycles
        if (cyc_n == 30000) begin
            bad_count++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(astg_pkg::ADR_CTRL, 32'h8, 32'hFFFFFFFF);
        rd(astg_pkg::ADR_TCFG, 32'h4, 32'hF);
        rd(astg_pkg::ADR_FPB, 32'h1, 32'hFF);
        rd(8'h18, 32'h0, 32'hFFFFFFFF);
        trig(1);
        chk_out(n_exp, want);
        fpb = 8'h02 + 8'(rnd() % 3);
        wb(1'b1, astg_pkg::ADR_FPB, {24'h0, fpb});
        wb(1'b1, astg_pkg::ADR_FPB, 32'h0);
        rd(astg_pkg::ADR_FPB, {24'h0, fpb}, 32'hFF);
        wb(1'b1, astg_pkg::ADR_TCFG, 32'h1);
        wb(1'b1, astg_pkg::ADR_CTRL, 32'hB);
        rd(astg_pkg::ADR_STATUS, 32'h5, 32'h7);
        trig(0);
        chk_out(n_exp, want);
        wb(1'b1, astg_pkg::ADR_TSW, 32'h1);
        rd(astg_pkg::ADR_STATUS, 32'h6, 32'hFF07);
        trig(1);
        wb(1'b1, astg_pkg::ADR_TSW, 32'h1);
        burst(int'(fpb) - 1);
        noise <= 1'b1;
        for (int p = 1; p >= 0; p--) begin
            wb(1'b1, astg_pkg::ADR_TCFG, 32'h3 | (32'(p) << 3));
            if (p == 1) begin
                edge_line;
                rd(astg_pkg::ADR_STATUS, 32'h5, 32'h7);
            end
            edge_line;
            rd(astg_pkg::ADR_STATUS, 32'h6, 32'h7);
            chk_out({30'h0, wacq, wfrm}, 32'h1);
            burst(int'(fpb));
        end
        wb(1'b1, astg_pkg::ADR_TCFG, 32'h0);
        rd(astg_pkg::ADR_STATUS, 32'h2, 32'h3);
        repeat (int'(fpb) + 1) trig(1);
        rd(astg_pkg::ADR_STATUS, 32'h2, 32'h3);
        wb(1'b1, astg_pkg::ADR_TSEL, 32'h1);
        wb(1'b1, astg_pkg::ADR_TCFG, 32'hB);
        wb(1'b1, astg_pkg::ADR_TSW, 32'h1);
        repeat (2) @(posedge clk);
        chk_out({28'h0, fgate, forg, fpol}, 32'hB);
        chk_out(n_sw, 1);
        rd(astg_pkg::ADR_STATUS, 32'h2, 32'h3);
        wb(1'b1, astg_pkg::ADR_TSEL, 32'h0);
        wb(1'b1, astg_pkg::ADR_CTRL, 32'hF);
        rd(astg_pkg::ADR_STATUS, 32'h0, 32'h7);
        wb(1'b1, astg_pkg::ADR_TCFG, 32'h1);
        wb(1'b1, astg_pkg::ADR_CTRL, 32'h9);
        wb(1'b1, astg_pkg::ADR_TSW, 32'h1);
        rd(astg_pkg::ADR_STATUS, 32'h0, 32'h3);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(astg_pkg::ADR_TCFG, 32'h4, 32'hF);
        rd(astg_pkg::ADR_CTRL, 32'h8, 32'hFFFFFFFF);
        tally_and_finish;
    end
endmodule

bind astg_top astg_top_sva SVA (.i_clk(i_clk), .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_frame_trig(i_frame_trig),
    .o_wb_ack(o_wb_ack), .o_expose_start(o_expose_start),
    .o_wait_acq_start(o_wait_acq_start),
    .o_wait_frame_start(o_wait_frame_start), .o_fs_origin(o_fs_origin),
    .o_fs_sw_trig(o_fs_sw_trig));
